// File: bles_pkg.sv
// Package for the byte lane endian steering block
package bles_pkg;
    localparam int WORD_W      = 32;
    localparam int BYTE_W      = 8;
    localparam int LANES       = 4;
    localparam int ADDR_LO_W   = 2;
    localparam logic ORDER_BIG    = 1'b1;
    localparam logic ORDER_LITTLE = 1'b0;
    localparam logic ORDER_RESET  = 1'b1;

    typedef enum logic [1:0] {
        BLES_SIZE_BYTE = 2'h0,
        BLES_SIZE_HALF = 2'h1,
        BLES_SIZE_WORD = 2'h2
    } bles_size_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  addr_lo;
        bles_size_t  size;
        logic        valid;
    } bles_req_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  lane_en;
        logic        order;
        logic        valid;
    } bles_lane_t;
endpackage

// File: bles_steer.sv
// Byte lane and endian steering for processor and expansion bus traffic
`timescale 1ns/1ps
`default_nettype none

module bles_steer (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                init_load_n,
    input  wire logic                init_order,
    input  wire logic                ctl_wr,
    input  wire logic                ctl_order,
    input  wire bles_pkg::bles_req_t cpu_req,
    input  wire logic                bus_cnt_cycle,
    input  wire logic                bus_order,
    input  wire bles_pkg::bles_req_t bus_req,
    output logic                     cpu_order,
    output bles_pkg::bles_lane_t     cpu_lane,
    output bles_pkg::bles_lane_t     bus_lane
);
    default clocking lane_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Lane index holding the byte at offset a for the given order
    function automatic logic [1:0] lane_of(input logic [1:0] a,
                                           input logic order);
        lane_of = (order == bles_pkg::ORDER_BIG) ? 2'h3 - a : a;
    endfunction

    // Byte enables for a sub-word access
    function automatic logic [3:0] enables(input logic [1:0] a,
                                           input bles_pkg::bles_size_t s,
                                           input logic order);
        logic [1:0] l0;
        logic [1:0] l1;
        l0 = lane_of(a, order);
        l1 = lane_of({a[1], 1'b1}, order);
        case (s)
            bles_pkg::BLES_SIZE_BYTE: enables = 4'h1 << l0;
            bles_pkg::BLES_SIZE_HALF:
                enables = (4'h1 << lane_of({a[1], 1'b0}, order)) |
                          (4'h1 << l1);
            default:                  enables = 4'hf;
        endcase
    endfunction

    // Places data from the low bits of the request into its lanes
    function automatic logic [31:0] place(input logic [31:0] d,
                                          input logic [1:0] a,
                                          input bles_pkg::bles_size_t s,
                                          input logic order);
        logic [31:0] r;
        r = d;
        case (s)
            bles_pkg::BLES_SIZE_BYTE:
                r = {4{d[7:0]}};
            bles_pkg::BLES_SIZE_HALF:
                r = (order == bles_pkg::ORDER_BIG) ?
                    {2{d[15:8], d[7:0]}} : {2{d[15:0]}};
            default: r = d;
        endcase
        place = r;
    endfunction

    logic       order_reg;
    logic       order_next;
    logic       load_seen_reg;
    logic       init_q1_reg;
    logic       init_q2_reg;
    logic       init_o1_reg;
    logic       init_o2_reg;
    logic       xfer_order_reg;
    wire logic  init_fire;
    wire logic  eff_bus_order;
    bles_pkg::bles_lane_t cpu_next;
    bles_pkg::bles_lane_t bus_next;

    // Synchronise the strap strobe and its value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_q1_reg <= 1'b1;
            init_q2_reg <= 1'b1;
            init_o1_reg <= 1'b0;
            init_o2_reg <= 1'b0;
        end else begin
            init_q1_reg <= init_load_n;
            init_q2_reg <= init_q1_reg;
            init_o1_reg <= init_order;
            init_o2_reg <= init_o1_reg;
        end
    end

    assign init_fire = !init_q2_reg && !load_seen_reg;
    assign order_next = init_fire ? init_o2_reg :
                        (ctl_wr ? ctl_order : order_reg);
    assign eff_bus_order = bus_cnt_cycle ? bus_order : xfer_order_reg;

    always_comb begin
        cpu_next.valid   = cpu_req.valid;
        cpu_next.order   = order_reg;
        cpu_next.lane_en = enables(cpu_req.addr_lo, cpu_req.size, order_reg);
        cpu_next.data    = place(cpu_req.data, cpu_req.addr_lo,
                                 cpu_req.size, order_reg);
        bus_next.valid   = bus_req.valid;
        bus_next.order   = eff_bus_order;
        bus_next.lane_en = enables(bus_req.addr_lo, bus_req.size,
                                   eff_bus_order);
        bus_next.data    = place(bus_req.data, bus_req.addr_lo,
                                 bus_req.size, eff_bus_order);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            order_reg      <= bles_pkg::ORDER_RESET;
            load_seen_reg  <= 1'b0;
            xfer_order_reg <= bles_pkg::ORDER_RESET;
            cpu_order      <= bles_pkg::ORDER_RESET;
            cpu_lane       <= '0;
            bus_lane       <= '0;
        end else begin
            order_reg      <= order_next;
            load_seen_reg  <= load_seen_reg | init_fire;
            xfer_order_reg <= eff_bus_order;
            cpu_order      <= order_next;
            cpu_lane       <= cpu_next;
            bus_lane       <= bus_next;
        end
    end

    // Processor order source checks
    a_init_load: assert property (
        init_fire |=> order_reg == $past(init_o2_reg))
        else $error("startup order not taken");
    a_init_out: assert property (
        init_fire |=> cpu_order == $past(init_o2_reg))
        else $error("startup order not on output");
    a_ctl_write: assert property (
        ctl_wr && !init_fire |=> order_reg == $past(ctl_order))
        else $error("control write order not taken");
    a_ctl_out: assert property (
        ctl_wr && !init_fire |=> cpu_order == $past(ctl_order))
        else $error("control write order not on output");
    a_order_hold: assert property (
        !ctl_wr && !init_fire |=> $stable(order_reg))
        else $error("order changed without cause");
    a_strobe_idle: assert property (
        init_q2_reg && !ctl_wr |=> $stable(order_reg))
        else $error("order changed with strobe high");
    a_load_once: assert property (
        load_seen_reg |=> load_seen_reg)
        else $error("startup load repeated");

    // Processor lane map checks
    a_big_byte0: assert property (
        cpu_req.valid && cpu_req.size == bles_pkg::BLES_SIZE_BYTE &&
        cpu_req.addr_lo == 2'h0 && order_reg == bles_pkg::ORDER_BIG
        |=> cpu_lane.lane_en == 4'h8)
        else $error("big byte 0 not on top lane");
    a_big_byte3: assert property (
        cpu_req.valid && cpu_req.size == bles_pkg::BLES_SIZE_BYTE &&
        cpu_req.addr_lo == 2'h3 && order_reg == bles_pkg::ORDER_BIG
        |=> cpu_lane.lane_en == 4'h1)
        else $error("big byte 3 not on low lane");
    a_little_byte0: assert property (
        cpu_req.valid && cpu_req.size == bles_pkg::BLES_SIZE_BYTE &&
        cpu_req.addr_lo == 2'h0 && order_reg == bles_pkg::ORDER_LITTLE
        |=> cpu_lane.lane_en == 4'h1)
        else $error("little byte 0 not on low lane");
    a_little_byte3: assert property (
        cpu_req.valid && cpu_req.size == bles_pkg::BLES_SIZE_BYTE &&
        cpu_req.addr_lo == 2'h3 && order_reg == bles_pkg::ORDER_LITTLE
        |=> cpu_lane.lane_en == 4'h8)
        else $error("little byte 3 not on top lane");
    a_byte_onehot: assert property (
        cpu_req.valid && cpu_req.size == bles_pkg::BLES_SIZE_BYTE
        |=> $onehot(cpu_lane.lane_en))
        else $error("byte access not on one lane");
    a_byte_copy: assert property (
        cpu_req.valid && cpu_req.size == bles_pkg::BLES_SIZE_BYTE
        |=> cpu_lane.data == {4{$past(cpu_req.data[7:0])}})
        else $error("byte not copied to every lane");
    a_half_low: assert property (
        cpu_req.valid && cpu_req.size == bles_pkg::BLES_SIZE_HALF &&
        cpu_req.addr_lo[1] == (order_reg == bles_pkg::ORDER_BIG)
        |=> cpu_lane.lane_en == 4'h3)
        else $error("half not on low lane pair");
    a_half_high: assert property (
        cpu_req.valid && cpu_req.size == bles_pkg::BLES_SIZE_HALF &&
        cpu_req.addr_lo[1] != (order_reg == bles_pkg::ORDER_BIG)
        |=> cpu_lane.lane_en == 4'hc)
        else $error("half not on high lane pair");
    a_word_pass: assert property (
        cpu_req.size == bles_pkg::BLES_SIZE_WORD
        |=> cpu_lane.data == $past(cpu_req.data))
        else $error("word data reordered");
    a_word_lanes: assert property (
        cpu_req.valid && cpu_req.size == bles_pkg::BLES_SIZE_WORD
        |=> cpu_lane.lane_en == 4'hf)
        else $error("word not on all lanes");

    // Expansion bus checks
    a_bus_order: assert property (
        bus_cnt_cycle |=> bus_lane.order == $past(bus_order) ##1
        ($past(bus_cnt_cycle) || bus_lane.order == $past(bus_order, 2)))
        else $error("transfer order not kept");
    a_bus_little: assert property (
        bus_cnt_cycle && bus_req.valid &&
        bus_order == bles_pkg::ORDER_LITTLE &&
        bus_req.size == bles_pkg::BLES_SIZE_BYTE && bus_req.addr_lo == 2'h0
        |=> bus_lane.lane_en == 4'h1)
        else $error("little transfer byte 0 not on low lane");
    a_bus_big: assert property (
        bus_cnt_cycle && bus_req.valid &&
        bus_order == bles_pkg::ORDER_BIG &&
        bus_req.size == bles_pkg::BLES_SIZE_HALF && bus_req.addr_lo == 2'h2
        |=> bus_lane.lane_en == 4'h3)
        else $error("big transfer half 2 not on low lanes");

    // Main scenarios
    c_init: cover property (init_fire);
    c_swap: cover property (ctl_wr && ctl_order != order_reg);
    c_bus_little: cover property (
        bus_cnt_cycle && bus_order == bles_pkg::ORDER_LITTLE);
    c_half_big: cover property (
        cpu_req.valid && cpu_req.size == bles_pkg::BLES_SIZE_HALF &&
        order_reg == bles_pkg::ORDER_BIG);
    c_late_load: cover property (!init_q2_reg && load_seen_reg);
endmodule // bles_steer

`default_nettype wire

// File: bles_far_end.sv
// Expansion bus initiator model for the steering block
`timescale 1ns/1ps
`default_nettype none
module bles_far_end (
    input  wire logic           clk,
    output var logic            cnt_cycle,
    output var logic            order,
    output bles_pkg::bles_req_t req
);
    initial begin
        cnt_cycle = 1'b0;
        order = 1'b1;
        req = '0;
    end
    // One transfer cycle; a count cycle carries the order bit
    task automatic send(input int cnt, input int ord,
                        input bles_pkg::bles_req_t r);
        cnt_cycle <= 1'(cnt);
        order <= (cnt != 0) ? 1'(ord) : ~order;
        req <= r;
        @(posedge clk);
        r.valid = 1'b0;
        r.data = ~r.data;
        cnt_cycle <= 1'b0;
        order <= ~order;
        req <= r;
    endtask
endmodule // bles_far_end
`default_nettype wire

// File: byte_lane_endian_steering_test.sv
// Testbench for the byte lane endian steering block
`timescale 1ns/1ps
`default_nettype none
module byte_lane_endian_steering_test;
    logic                 clk = 1'b0;
    logic                 rst_n, init_load_n, init_order;
    logic                 ctl_wr, ctl_order, cpu_order;
    logic                 bus_cnt_cycle, bus_order;
    bles_pkg::bles_req_t  cpu_req, bus_req;
    bles_pkg::bles_lane_t cpu_lane, bus_lane;
    int                   errors = 0;
    int                   checks_done = 0;

    always #10 clk = ~clk;

    bles_steer bles_steer_i (.clk(clk), .rst_n(rst_n),
        .init_load_n(init_load_n), .init_order(init_order),
        .ctl_wr(ctl_wr), .ctl_order(ctl_order), .cpu_req(cpu_req),
        .bus_cnt_cycle(bus_cnt_cycle), .bus_order(bus_order),
        .bus_req(bus_req), .cpu_order(cpu_order),
        .cpu_lane(cpu_lane), .bus_lane(bus_lane));
    bles_far_end bles_far_end_i (.clk(clk), .cnt_cycle(bus_cnt_cycle),
        .order(bus_order), .req(bus_req));

    task automatic chk(input logic [37:0] g, input logic [37:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_order(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One request on either side, then compare the steered output
    task automatic xfer(input int bus, cnt, ord, s, a, big);
        bles_pkg::bles_req_t  r;
        bles_pkg::bles_req_t  idle;
        bles_pkg::bles_lane_t got;
        logic [31:0]          d;
        logic [3:0]           en;
        logic [1:0]           l;
        l = (big != 0) ? 2'(3 - a) : 2'(a);
        en = (s == 2) ? 4'hf : (s == 1) ? ((big != 0) ^ (a > 1) ? 4'hc
             : 4'h3) : 4'h1 << l;
        r.data = 32'h01234567;
        r.addr_lo = 2'(a);
        r.size = bles_pkg::bles_size_t'(s);
        r.valid = 1'b1;
        d = (s == 2) ? r.data : (s == 1) ? {2{r.data[15:0]}}
            : {4{r.data[7:0]}};
        idle = r;
        idle.data = ~r.data;
        idle.valid = 1'b0;
        @(posedge clk);
        if (bus != 0) begin
            bles_far_end_i.send(cnt, ord, r);
        end else begin
            cpu_req <= r;
            @(posedge clk);
            cpu_req <= idle;
        end
        @(negedge clk);
        got = (bus != 0) ? bus_lane : cpu_lane;
        chk(got, {d, en, 1'(big), 1'b1});
    endtask

    task automatic init_scn(input int o, input int e);
        @(posedge clk);
        init_order <= 1'(o);
        init_load_n <= 1'b0;
        repeat (5) @(posedge clk);
        init_load_n <= 1'b1;
        @(negedge clk);
        chk_order(cpu_order, 1'(e));
    endtask

    task automatic ctl_scn(input int o);
        @(posedge clk);
        ctl_wr <= 1'b1;
        ctl_order <= 1'(o);
        @(posedge clk);
        ctl_wr <= 1'b0;
        @(negedge clk);
        chk_order(cpu_order, 1'(o));
    endtask

    task automatic cpu_scn(input int big);
        for (int s = 0; s < 3; s++)
            for (int a = 0; a < 4; a += 1 << s)
                xfer(0, 0, 0, s, a, big);
    endtask

    task automatic bus_scn();
        xfer(1, 1, 0, 0, 0, 0);
        xfer(1, 0, 1, 0, 3, 0);
        xfer(1, 1, 1, 1, 2, 1);
        xfer(1, 0, 0, 2, 0, 1);
    endtask

    // Reset in mid-run: lane outputs clear, cpu_order returns to big and the startup load is re-armed
    task automatic rst_scn();
        @(posedge clk);
        rst_n <= 1'b0;
        cpu_req <= '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_order(cpu_order, 1'b1);
        chk(cpu_lane, 38'h0);
        chk(bus_lane, 38'h0);
    endtask

    initial begin
        rst_n = 1'b0;
        init_load_n = 1'b1;
        init_order = 1'b1;
        ctl_wr = 1'b0;
        ctl_order = 1'b1;
        cpu_req = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_order(cpu_order, 1'b1);
        init_scn(0, 0);
        cpu_scn(0);
        init_scn(1, 0);
        ctl_scn(1);
        cpu_scn(1);
        ctl_scn(0);
        bus_scn();
        rst_scn();
        init_scn(0, 0);
        print_verdict();
    end

    initial begin
        #100000;
        errors++;
        print_verdict();
    end
endmodule // byte_lane_endian_steering_test
`default_nettype wire
